// ===== verilog/sidr_pkg.sv
/*
 * Package for the sensor identification register bank: offsets,
 * field positions, reset values and identity defaults.
 * Assumes an 8-bit register port with byte addresses.
 */
package sidr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_CHIP_TYPE = 8'h00;
    localparam logic [7:0] OFS_CHIP_MAKER = 8'h01;
    localparam logic [7:0] OFS_CHIP_REV = 8'h02;
    localparam logic [7:0] OFS_MODULE_KIND = 8'h03;
    localparam logic [7:0] OFS_MODULE_MAKER = 8'h04;
    localparam logic [7:0] OFS_MODULE_REV = 8'h05;
    localparam logic [7:0] OFS_USER_INFO = 8'h06;
    localparam logic [7:0] OFS_PART_RANGE = 8'h09;
    localparam logic [7:0] OFS_SERIAL0 = 8'h0A;
    localparam logic [7:0] OFS_SERIAL1 = 8'h0B;
    localparam logic [7:0] OFS_SERIAL2 = 8'h0C;
    localparam logic [7:0] OFS_SERIAL3 = 8'h0D;
    localparam logic [7:0] OFS_PROTO_REV = 8'h10;
    // bit 4 of the chip revision carries the ordering variant
    localparam int CHIP_REV_VARIANT_BIT = 4;
    localparam logic [7:0] CHIP_REV_FIXED = 8'h20;
    localparam int MODULE_FIELD_W = 3;
    localparam logic [2:0] MODULE_FIELD_RESET = 3'h0;
    localparam logic [7:0] USER_INFO_RESET = 8'h00;
    localparam logic [7:0] PROTO_REV_VALUE = 8'h01;
    localparam int SERIAL_COUNT_W = 13;
    localparam int LOT_W = 19;
    localparam logic [7:0] READ_ZERO = 8'h00;

    typedef struct packed {
        logic [2:0] module_kind;
        logic [2:0] module_maker;
        logic [2:0] module_revision;
        logic [7:0] user_info_byte;
    } sidr_user_nvm_type;

    typedef struct packed {
        logic [7:0] part_range_code;
        logic [LOT_W-1:0] lot_number;
        logic [SERIAL_COUNT_W-1:0] serial_count;
    } sidr_factory_nvm_type;
endpackage

// ===== verilog/sidr_ident_regs.sv
/*
 * Identification and traceability register bank of the sensor.
 * Assumes nonvolatile images arrive from the memory loader on the same
 * clock and are stable while valid; register port is same-clock logic.
 */
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
// What this block does
// - chip type code, read-only, at the lowest address
// - chip maker code, read-only, at the second address
// - read-only chip revision; bit 4 selects ordering variant, rest fixed
// - 3-bit user module kind in bits 2..0, upper zero, default zero
// - 3-bit user module maker in bits 2..0, upper zero, default zero
// - 3-bit user module revision in bits 2..0, upper zero, default zero
// - user info byte, default zero, never steers device behaviour
// - factory part number byte, read only, affects nothing else
// - part number value names range and axis, 25 g to 375 g
// - 32-bit serial identifier over four bytes, low byte first
// - serial count in low 13 bits, lot number in upper 19
// - serial counts and lot numbers start at one
// - protocol revision always reads the third-generation code
module sidr_ident_regs #(
    // identity codes: arbitrary neutral values
    parameter logic [7:0] CHIP_TYPE_VALUE = 8'h5A,
    parameter logic [7:0] CHIP_MAKER_VALUE = 8'h3C,
    parameter logic ORDER_VARIANT = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [sidr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sidr_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [sidr_pkg::DATA_W-1:0] reg_rdata,
    input wire logic user_nvm_valid,
    input wire sidr_pkg::sidr_user_nvm_type user_nvm,
    input wire logic factory_nvm_valid,
    input wire sidr_pkg::sidr_factory_nvm_type factory_nvm
);
    import sidr_pkg::*;

    sidr_user_nvm_type user_img;
    sidr_factory_nvm_type fact_img;
    logic [31:0] serial_identifier;
    logic [7:0] chip_revision_code;
    logic [7:0] next_rdata;

    // images latch from the nonvolatile loader only; the bus cannot touch them
    always_ff @(posedge clk) begin
        if (rst) begin
            user_img.module_kind <= MODULE_FIELD_RESET;
            user_img.module_maker <= MODULE_FIELD_RESET;
            user_img.module_revision <= MODULE_FIELD_RESET;
            user_img.user_info_byte <= USER_INFO_RESET;
        end else if (user_nvm_valid) begin
            user_img <= user_nvm;
        end
    end

    // factory contents are not interpreted; part number encoding is the fuse's
    always_ff @(posedge clk) begin
        if (rst) begin
            fact_img <= '0;
        end else if (factory_nvm_valid) begin
            fact_img <= factory_nvm;
        end
    end

    assign serial_identifier = {fact_img.lot_number, fact_img.serial_count};

    always_comb begin
        chip_revision_code = CHIP_REV_FIXED;
        chip_revision_code[CHIP_REV_VARIANT_BIT] = ORDER_VARIANT;
    end

    // reg_write and reg_wdata deliberately unused: all registers read-only
    always_comb begin
        next_rdata = READ_ZERO;
        case (reg_addr)
            OFS_CHIP_TYPE: next_rdata = CHIP_TYPE_VALUE;
            OFS_CHIP_MAKER: next_rdata = CHIP_MAKER_VALUE;
            OFS_CHIP_REV: next_rdata = chip_revision_code;
            OFS_MODULE_KIND: next_rdata = {5'h00, user_img.module_kind};
            OFS_MODULE_MAKER: next_rdata = {5'h00, user_img.module_maker};
            OFS_MODULE_REV: next_rdata = {5'h00, user_img.module_revision};
            OFS_USER_INFO: next_rdata = user_img.user_info_byte;
            OFS_PART_RANGE: next_rdata = fact_img.part_range_code;
            OFS_SERIAL0: next_rdata = serial_identifier[7:0];
            OFS_SERIAL1: next_rdata = serial_identifier[15:8];
            OFS_SERIAL2: next_rdata = serial_identifier[23:16];
            OFS_SERIAL3: next_rdata = serial_identifier[31:24];
            OFS_PROTO_REV: next_rdata = PROTO_REV_VALUE;
            default: next_rdata = READ_ZERO;
        endcase
    end

    // data only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= READ_ZERO;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= READ_ZERO;
        end
    end

    a_proto_rev: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_PROTO_REV |=> reg_rdata == PROTO_REV_VALUE)
        else $error("protocol revision misread");
    a_chip_type: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_CHIP_TYPE |=> reg_rdata == CHIP_TYPE_VALUE)
        else $error("chip type misread");
    a_chip_maker: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_CHIP_MAKER |=> reg_rdata == CHIP_MAKER_VALUE)
        else $error("chip maker misread");
    a_chip_rev: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_CHIP_REV |=> reg_rdata[4] == ORDER_VARIANT
        && {reg_rdata[7:5], reg_rdata[3:0]} == 7'h10)
        else $error("chip revision misread");
    a_kind_upper: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_MODULE_KIND |=> reg_rdata[7:3] == 5'h00)
        else $error("module kind upper bits set");
    a_kind_value: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_MODULE_KIND
        |=> reg_rdata[2:0] == $past(user_img.module_kind))
        else $error("module kind misread");
    a_maker_upper: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_MODULE_MAKER |=> reg_rdata[7:3] == 5'h00)
        else $error("module maker upper bits set");
    a_maker_value: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_MODULE_MAKER
        |=> reg_rdata[2:0] == $past(user_img.module_maker))
        else $error("module maker misread");
    a_rev_upper: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_MODULE_REV |=> reg_rdata[7:3] == 5'h00)
        else $error("module revision upper bits set");
    a_rev_value: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_MODULE_REV
        |=> reg_rdata[2:0] == $past(user_img.module_revision))
        else $error("module revision misread");
    // no disable here: the check is about what reset itself leaves behind
    a_user_default: assert property (@(posedge clk)
        rst |=> user_img.module_kind == MODULE_FIELD_RESET
        && user_img.module_maker == MODULE_FIELD_RESET
        && user_img.module_revision == MODULE_FIELD_RESET
        && user_img.user_info_byte == USER_INFO_RESET)
        else $error("user image not cleared by reset");
    a_user_info: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_USER_INFO && !user_nvm_valid
        |=> reg_rdata == $past(user_img.user_info_byte))
        else $error("user info misread");
    a_serial_low: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_SERIAL0
        |=> reg_rdata == $past(fact_img.serial_count[7:0]))
        else $error("serial low byte misread");
    // byte 1 straddles the count and lot boundary at bit 13
    a_serial_mid1: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_SERIAL1
        |=> reg_rdata[7:5] == $past(fact_img.lot_number[2:0])
        && reg_rdata[4:0] == $past(fact_img.serial_count[12:8]))
        else $error("serial byte one misread");
    a_serial_mid2: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_SERIAL2
        |=> reg_rdata == $past(fact_img.lot_number[10:3]))
        else $error("serial byte two misread");
    a_serial_lot: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_SERIAL3
        |=> reg_rdata == $past(fact_img.lot_number[18:11]))
        else $error("lot number misplaced");
    a_part_range: assert property (@(posedge clk) disable iff (rst)
        reg_read && reg_addr == OFS_PART_RANGE
        |=> reg_rdata == $past(fact_img.part_range_code))
        else $error("part number misread");
    a_write_ignored: assert property (@(posedge clk) disable iff (rst)
        reg_write && !user_nvm_valid && !factory_nvm_valid
        |=> user_img == $past(user_img) && fact_img == $past(fact_img))
        else $error("write altered a register");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
        reg_read && (reg_addr inside {8'h07, 8'h08, 8'h0E, 8'h0F} || reg_addr > OFS_PROTO_REV)
        |=> reg_rdata == READ_ZERO)
        else $error("unmapped address read nonzero");
    a_idle_zero: assert property (@(posedge clk) disable iff (rst)
        !reg_read |=> reg_rdata == READ_ZERO)
        else $error("read data outside read slot");
endmodule

// ===== verif/sidr_bus_master.sv
/*
 * Register-port master standing in for the link controller.
 * Assumes one clock shared with the register bank; no wait states.
 */
`timescale 1ns/1ns
module sidr_bus_master (
    input wire logic clk,
    output logic [sidr_pkg::ADDR_W-1:0] reg_addr,
    output logic [sidr_pkg::DATA_W-1:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [sidr_pkg::DATA_W-1:0] reg_rdata
);
    import sidr_pkg::*;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    // data stands only in the cycle after the strobe, so sample it there
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
endmodule

// ===== verif/sidr_ident_regs_test.sv
/*
 * Self-checking bench for the identification register bank.
 * Assumes the bus master model drives the register port.
 */
`timescale 1ns/1ns
`define CHK(name, exp, got) begin checked++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", name, exp, got); end end
module sidr_ident_regs_test;
    import sidr_pkg::*;
    localparam logic [7:0] TYPE_CODE = 8'h6B; // arbitrary
    localparam logic [7:0] MAKER_CODE = 8'h4D; // arbitrary
    localparam logic VARIANT = 1'b0;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] rd_data;
    logic reg_write;
    logic reg_read;
    logic user_nvm_valid = 1'b0;
    logic factory_nvm_valid = 1'b0;
    sidr_user_nvm_type user_nvm = '0;
    sidr_factory_nvm_type factory_nvm = '0;
    int err_count = 0;
    int checked = 0;
    always #10 clk = ~clk;
    sidr_ident_regs #(.CHIP_TYPE_VALUE(TYPE_CODE), .CHIP_MAKER_VALUE(MAKER_CODE),
        .ORDER_VARIANT(VARIANT)) u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .user_nvm_valid(user_nvm_valid), .user_nvm(user_nvm),
        .factory_nvm_valid(factory_nvm_valid), .factory_nvm(factory_nvm));
    sidr_bus_master u_bus (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
    function automatic logic [7:0] expect_byte(input logic [7:0] a);
        logic [31:0] serial_id;
        serial_id = {factory_nvm.lot_number, factory_nvm.serial_count};
        case (a)
            8'h00: return TYPE_CODE;
            8'h01: return MAKER_CODE;
            8'h02: return {2'b00, 1'b1, VARIANT, 4'h0};
            8'h03: return {5'h00, user_nvm.module_kind};
            8'h04: return {5'h00, user_nvm.module_maker};
            8'h05: return {5'h00, user_nvm.module_revision};
            8'h06: return user_nvm.user_info_byte;
            8'h09: return factory_nvm.part_range_code;
            8'h0A: return serial_id[7:0];
            8'h0B: return serial_id[15:8];
            8'h0C: return serial_id[23:16];
            8'h0D: return serial_id[31:24];
            8'h10: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction
    task automatic check_all(input string what);
        logic [7:0] addr;
        for (int a = 0; a <= 18; a++) begin
            addr = (a == 18) ? 8'hFF : 8'(a);
            u_bus.read(addr, rd_data);
            `CHK(what, expect_byte(addr), rd_data)
        end
        @(posedge clk);
        #1 `CHK("idle read data", 8'h00, reg_rdata)
    endtask
    task automatic stop_test();
        $display("errors %0d comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #(20 * 5000);
        err_count++;
        stop_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_all("reset image");
        @(posedge clk);
        user_nvm_valid <= 1'b1;
        factory_nvm_valid <= 1'b1;
        // lot and count both start at one, so use count 1 on a large lot
        user_nvm <= {3'h5, 3'h7, 3'h2, 8'hA5};
        factory_nvm <= {8'h4E, 19'h4ABCD, 13'h0001};
        @(posedge clk);
        user_nvm_valid <= 1'b0;
        factory_nvm_valid <= 1'b0;
        check_all("loaded image");
        for (int a = 0; a <= 17; a++) u_bus.write(8'(a), 8'hFF);
        check_all("after writes");
        @(posedge clk);
        rst <= 1'b1;
        user_nvm <= '0;
        factory_nvm <= '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_all("second reset");
        stop_test();
    end
endmodule
